// ===== pkg/pin_filter_pkg.sv
// Shared constants, types and helpers for the pin debounce and power-up block
package pin_filter_pkg;

    // ********************************************************************
    // Clock rates and sample tick generation
    // ********************************************************************
    // System clock and filter sample rate, in MHz; the ratio sets the tick rate
    localparam logic [6:0] SYS_CLK_MHZ = 7'h64;
    localparam logic [6:0] FILT_CLK_MHZ = 7'h28;
    // Nominal filter sample period in ps, derived from the filter rate
    localparam int FILT_PERIOD_PS = 1000000 / int'(FILT_CLK_MHZ);

    // ********************************************************************
    // Consecutive-sample counts per filter setting
    // ********************************************************************
    localparam int CNT_W = 17;
    localparam logic [16:0] N_SHORT = 17'h00005;
    localparam logic [16:0] N_MID = 17'h00101;
    // Long count exceeds 4096 cycles, so the top module takes it as a parameter
    localparam int N_LONG_DEFAULT = 101800;

    // ********************************************************************
    // Line counts and input indices
    // ********************************************************************
    localparam int NUM_FP = 16;
    localparam int NUM_DL = 8;
    localparam int NUM_TB = 8;
    localparam int NUM_IN = NUM_FP + NUM_TB + 1;
    localparam int NUM_LINES = NUM_FP + NUM_DL;
    localparam int TB_BASE = NUM_FP;
    localparam int STAR_IDX = NUM_FP + NUM_TB;

    // ********************************************************************
    // Register map (byte addresses, one word each)
    // ********************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_FILT_PIN = 8'h00;
    localparam logic [7:0] REG_FILT_BUS = 8'h04;
    localparam logic [7:0] REG_ROUTE = 8'h08;
    localparam logic [7:0] REG_DRV_EN = 8'h0C;
    localparam logic [7:0] REG_DRV_VAL = 8'h10;
    localparam logic [7:0] REG_FILT_LVL = 8'h14;
    localparam logic [7:0] REG_RAW_LVL = 8'h18;
    localparam logic [7:0] REG_LINE_IN = 8'h1C;
    // Field positions
    localparam int ROUTE_B2P_LSB = 8;
    localparam int FILT_BUS_W = 2 * (NUM_TB + 1);

    // ********************************************************************
    // Power-up codes and output-capable masks
    // ********************************************************************
    localparam logic [1:0] PU_HIZ = 2'h0;
    localparam logic [1:0] PU_LOW = 2'h1;
    localparam logic [1:0] PU_HIGH = 2'h2;
    localparam logic [23:0] OUT_MASK_FULL = 24'hFFFFFF;
    localparam logic [23:0] OUT_MASK_ISO = 24'h0003C0;

    // Filter setting of one input
    typedef enum logic [1:0] {FILT_OFF, FILT_SHORT, FILT_MID, FILT_LONG} filt_set_t;

    // Output and enable of every driven pin group
    typedef struct packed {
        logic [15:0] fp;
        logic [7:0] dl;
        logic [7:0] tb;
    } pin_group_t;

    // Stored power-up image: port enable (isolated variant) and per-line codes
    typedef struct packed {
        logic port_en;
        logic [23:0][1:0] mode;
    } pu_image_t;

    // Sample count that a setting needs before a level change passes
    function automatic logic [16:0] filt_count(input filt_set_t s, input logic [16:0] n_long);
        logic [16:0] n;
        n = N_SHORT;
        case (s)
            FILT_MID: n = N_MID;
            FILT_LONG: n = n_long;
            default: n = N_SHORT;
        endcase
        return n;
    endfunction

endpackage

// ===== verilog/debounce_cell.sv
// One debounce filter channel: counter, held level and bypass
`timescale 1ns/10ps
module debounce_cell
    import pin_filter_pkg::*;
#(
    parameter logic [16:0] N_LONG = 17'(N_LONG_DEFAULT)
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic raw_i,
    input wire filt_set_t setting_i,
    output logic filtered_o
);

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        logic level;
        logic [16:0] cnt;
    } cell_state_t;

    localparam cell_state_t CELL_RESET = '{level: 1'b0, cnt: 17'h00000};

    cell_state_t st_r; // Registered state
    cell_state_t st_nxt; // Next state
    logic [16:0] n_need; // Samples needed for this setting

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    always_comb begin
        st_nxt = st_r;
        n_need = filt_count(setting_i, N_LONG);
        if (setting_i == FILT_OFF) begin
            // Disabled: follow the raw input every clock
            st_nxt.level = raw_i;
            st_nxt.cnt = '0;
        end else if (tick_i) begin
            // One sample per filter tick
            if (raw_i == st_r.level) begin
                st_nxt.cnt = '0;
            end else if (st_r.cnt + 17'h00001 >= n_need) begin
                // N opposite samples in a row: the change passes
                st_nxt.level = raw_i;
                st_nxt.cnt = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + 17'h00001;
            end
        end
    end

    // Sync reset, one register for all state
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r <= CELL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign filtered_o = st_r.level;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence last_opposite_s;
        tick_i && setting_i != FILT_OFF && raw_i != st_r.level && st_r.cnt + 17'h00001 >= n_need;
    endsequence

    hold_between_ticks_a: assert property (!tick_i && setting_i != FILT_OFF && $stable(setting_i) |=> $stable(st_r.level)) else $error("level moved without a tick");
    pass_after_n_a: assert property (last_opposite_s |=> st_r.level == $past(raw_i) && st_r.cnt == 17'h00000) else $error("change did not pass at count");
    restart_on_match_a: assert property (tick_i && setting_i != FILT_OFF && raw_i == st_r.level |=> st_r.cnt == 17'h00000) else $error("counter not restarted");
    bypass_follow_a: assert property (setting_i == FILT_OFF |=> st_r.level == $past(raw_i)) else $error("bypass not following");
    short_blocks_a: assert property (setting_i == FILT_SHORT && st_r.cnt != 17'h00000 |-> st_r.cnt < N_SHORT) else $error("short count overran");

endmodule

// ===== verilog/pin_debounce_powerup.sv
// Pin debounce filters, raw routing and power-up drive state of the function lines
`timescale 1ns/10ps

// Behaviour
// - Every function, bus and star input filterable.
// - Filter samples on 40 MHz tick.
// - Level changes after N equal opposite samples.
// - N is 5, 257 or ~101800.
// - Short setting passes 125 ns, blocks 100.
// - Each input keeps its own setting.
// - Filters start disabled after reset.
// - Direct pin/bus routes forward raw signal.
// - Reset leaves all lines high impedance.
// - Lines power up hi-z, low or high.
// - Isolated port enable is whole-port, default off.
// - Enabled isolated port drives programmed levels.
module pin_debounce_powerup
    import pin_filter_pkg::*;
#(
    parameter logic ISOLATED = 1'b0,
    parameter logic [16:0] N_LONG = 17'(N_LONG_DEFAULT)
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Stored power-up image, caught after reset release
    input wire pu_image_t pu_image_i,
    // Pin inputs
    input wire logic [15:0] fp_in_i,
    input wire logic [7:0] dl_in_i,
    input wire logic [7:0] tb_in_i,
    input wire logic star_in_i,
    // Pin drive
    output pin_group_t pin_out_o,
    output pin_group_t pin_oe_o,
    // Filtered levels to the routing fabric
    output logic [24:0] filtered_o
);

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        logic [24:0][1:0] settings; // Filter setting per input
        logic [15:0] route; // Raw routes pin->bus [7:0], bus->pin [15:8]
        logic [23:0] drv_en; // Runtime drive enable per line
        logic [23:0] drv_val; // Runtime drive level per line
        logic [6:0] acc; // Fractional tick accumulator
        logic tick; // Filter sample tick
        logic pu_pending; // Power-up image still to load
        logic [31:0] rdata; // Read data register
        pin_group_t pout; // Pin output levels
        pin_group_t poe; // Pin output enables
    } top_state_t;

    // Everything quiet, filters off, lines undriven, image load pending
    localparam top_state_t TOP_RESET = '{
        settings: '0,
        route: 16'h0000,
        drv_en: 24'h000000,
        drv_val: 24'h000000,
        acc: 7'h00,
        tick: 1'b0,
        pu_pending: 1'b1,
        rdata: 32'h00000000,
        pout: '0,
        poe: '0
    };

    // Lines that can drive at all in this variant
    localparam logic [23:0] OUT_MASK = ISOLATED ? OUT_MASK_ISO : OUT_MASK_FULL;

    top_state_t st_r; // Registered state
    top_state_t st_nxt; // Next state
    logic [24:0] raw_in; // Raw filter inputs, star on top
    logic [24:0] filt_lvl; // Filtered levels from the cells
    logic [6:0] acc_sum; // Accumulator plus step

    assign raw_in = {star_in_i, tb_in_i, fp_in_i};

    // ********************************************************************
    // Filter channels
    // ********************************************************************
    // One cell per input keeps its own counter and held level
    for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_cell
        debounce_cell #(
            .N_LONG(N_LONG)
        ) u_cell (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .tick_i(st_r.tick),
            .raw_i(raw_in[gi]),
            .setting_i(filt_set_t'(st_r.settings[gi])),
            .filtered_o(filt_lvl[gi])
        );
    end

    // ********************************************************************
    // Power-up image decode
    // ********************************************************************
    // Turns the stored image into enable bits for every line
    function automatic logic [23:0] pu_enable(input pu_image_t img);
        logic [23:0] en;
        en = '0;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (ISOLATED) begin
                // Whole port switches together; codes only give levels
                en[i] = img.port_en;
            end else begin
                en[i] = (img.mode[i] == PU_LOW) || (img.mode[i] == PU_HIGH);
            end
        end
        return en & OUT_MASK;
    endfunction

    // Turns the stored image into drive levels for every line
    function automatic logic [23:0] pu_level(input pu_image_t img);
        logic [23:0] lv;
        lv = '0;
        for (int i = 0; i < NUM_LINES; i++) begin
            lv[i] = (img.mode[i] == PU_HIGH);
        end
        return lv & OUT_MASK;
    endfunction

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    always_comb begin
        st_nxt = st_r;
        acc_sum = st_r.acc + FILT_CLK_MHZ;

        // Tick at 40 per 100 clocks; spacing alternates 2 and 3 clocks,
        // which keeps the average sample rate exact at the cost of jitter
        if (acc_sum >= SYS_CLK_MHZ) begin
            st_nxt.acc = acc_sum - SYS_CLK_MHZ;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.acc = acc_sum;
            st_nxt.tick = 1'b0;
        end

        // First cycle after reset: take over the stored power-up image
        if (st_r.pu_pending) begin
            st_nxt.drv_en = pu_enable(pu_image_i);
            st_nxt.drv_val = pu_level(pu_image_i);
            st_nxt.pu_pending = 1'b0;
        end

        // Register writes; each word touches only its own inputs
        if (wr_i) begin
            case (addr_i)
                REG_FILT_PIN: begin
                    // Pin settings only; bus and star settings untouched
                    st_nxt.settings[NUM_FP-1:0] = wdata_i;
                end
                REG_FILT_BUS: begin
                    st_nxt.settings[NUM_IN-1:TB_BASE] = wdata_i[FILT_BUS_W-1:0];
                end
                REG_ROUTE: begin
                    st_nxt.route = wdata_i[15:0];
                end
                REG_DRV_EN: begin
                    // Lines that cannot drive in this variant stay off
                    st_nxt.drv_en = wdata_i[23:0] & OUT_MASK;
                end
                REG_DRV_VAL: begin
                    st_nxt.drv_val = wdata_i[23:0];
                end
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end

        // Register reads; data stand one cycle later
        st_nxt.rdata = 32'h00000000;
        if (rd_i) begin
            case (addr_i)
                REG_FILT_PIN: st_nxt.rdata = st_r.settings[NUM_FP-1:0];
                REG_FILT_BUS: st_nxt.rdata = 32'(st_r.settings[NUM_IN-1:TB_BASE]);
                REG_ROUTE: st_nxt.rdata = {16'h0000, st_r.route};
                REG_DRV_EN: st_nxt.rdata = {8'h00, st_r.drv_en};
                REG_DRV_VAL: st_nxt.rdata = {8'h00, st_r.drv_val};
                REG_FILT_LVL: st_nxt.rdata = {7'h00, filt_lvl};
                REG_RAW_LVL: st_nxt.rdata = {7'h00, raw_in};
                REG_LINE_IN: st_nxt.rdata = {24'h000000, dl_in_i};
                default: st_nxt.rdata = 32'h00000000;
            endcase
        end

        // Line drive from the runtime registers
        st_nxt.pout.fp = st_r.drv_val[NUM_FP-1:0];
        st_nxt.poe.fp = st_r.drv_en[NUM_FP-1:0];
        st_nxt.pout.dl = st_r.drv_val[NUM_LINES-1:NUM_FP];
        st_nxt.poe.dl = st_r.drv_en[NUM_LINES-1:NUM_FP];

        // Direct routes carry the raw level, never the filtered one,
        // so a filter setting cannot add delay to a forwarded trigger
        st_nxt.pout.tb = fp_in_i[NUM_TB-1:0];
        st_nxt.poe.tb = st_r.route[NUM_TB-1:0];
        for (int k = 0; k < NUM_TB; k++) begin
            if (st_r.route[ROUTE_B2P_LSB + k] && OUT_MASK[k]) begin
                st_nxt.pout.fp[k] = tb_in_i[k];
                st_nxt.poe.fp[k] = 1'b1;
            end
        end
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    // Sync reset: filters off and all lines undriven while held
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r <= TOP_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************************
    // Outputs, all from flip-flops
    // ********************************************************************
    assign rdata_o = st_r.rdata;
    assign pin_out_o = st_r.pout;
    assign pin_oe_o = st_r.poe;
    assign filtered_o = filt_lvl;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // A write to the pin settings; the check below wants stable bus settings after it
    sequence pin_set_write_s;
        wr_i && addr_i == REG_FILT_PIN;
    endsequence

    sequence pu_load_s;
        st_r.pu_pending ##1 !st_r.pu_pending;
    endsequence

    // Out of reset: nothing driven, filters off
    reset_hiz_a: assert property ($rose(rst_n_i) |-> st_r.poe == '0 && pin_oe_o == '0) else $error("line driven at reset");
    reset_filt_off_a: assert property ($rose(rst_n_i) |-> st_r.settings == '0) else $error("filter on after reset");

    // Tick never on two clocks in a row; the next one follows two or three clocks later
    tick_spacing_a: assert property (st_r.tick |=> !st_r.tick) else $error("ticks back to back");
    tick_rate_a: assert property (st_r.tick |-> ##[2:3] st_r.tick) else $error("tick gap too long");

    // Independent settings per input
    setting_indep_a: assert property (pin_set_write_s |=> $stable(st_r.settings[NUM_IN-1:TB_BASE])) else $error("bus setting disturbed");

    // Raw forwarding on a pin-to-bus route
    raw_route_a: assert property (st_r.route[0] |=> pin_oe_o.tb[0] && pin_out_o.tb[0] == $past(fp_in_i[0], 1)) else $error("route not raw");

    // Image taken once, in the cycle after release
    pu_load_a: assert property (pu_load_s |-> st_r.drv_en == pu_enable($past(pu_image_i, 1))) else $error("image not loaded");

    // Isolated variant never drives an input-only line
    iso_mask_a: assert property ((pin_oe_o.fp & ~OUT_MASK[NUM_FP-1:0]) == 16'h0000) else $error("input-only line driven");

    // Read data stand in the cycle after the strobe only
    read_once_a: assert property (!rd_i |=> rdata_o == 32'h00000000) else $error("read data without strobe");

endmodule

// ===== tb/pin_source_model.sv
// Behavioural model of the external sources that drive the device's input pins
`timescale 1ns/10ps
module pin_source_model (
    input wire logic clock_i,
    output logic [24:0] raw_o
);
    // ****************************************************************
    // Idle state
    // ****************************************************************
    // Undriven lines sit low, where the weak pull-down holds them
    initial begin
        raw_o = '0;
    end

    // ****************************************************************
    // Stimulus tasks
    // ****************************************************************
    // One high pulse of a whole number of clocks; level moves just after an edge
    task automatic pulse(input int idx, input int width);
        @(posedge clock_i);
        raw_o[idx] <= 1'b1;
        repeat (width) @(posedge clock_i);
        raw_o[idx] <= 1'b0;
    endtask

    // Contact bounce: two bursts split by a short dip, low for gap clocks
    task automatic bounce(input int idx, input int width, input int gap);
        pulse(idx, width);
        repeat (gap - 1) @(posedge clock_i);
        pulse(idx, width);
    endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the pin debounce filters and power-up drive state
`timescale 1ns/10ps
module tb;
    import pin_filter_pkg::*;
    // Long count shortened so the long setting runs in a few dozen clocks
    localparam logic [16:0] N_SIM = 17'h00014;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h00000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    pu_image_t pu_image_i = '0;
    pu_image_t img;
    logic [24:0] raw;
    logic [7:0] dl = 8'h00;
    pin_group_t pin_out_o;
    pin_group_t pin_oe_o;
    pin_group_t iso_oe;
    logic [24:0] filtered_o;
    logic [31:0] lfsr = 32'hFA1E;
    logic [31:0] rd_val;
    logic seen;
    int err_count = 0;
    int n_compared = 0;
    int w;

    // 100 MHz system clock
    always #5 clock_i = ~clock_i;

    pin_source_model src (.clock_i(clock_i), .raw_o(raw));

    pin_debounce_powerup #(.ISOLATED(1'b0), .N_LONG(N_SIM)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pu_image_i(pu_image_i),
        .fp_in_i(raw[15:0]), .dl_in_i(dl), .tb_in_i(raw[23:16]), .star_in_i(raw[24]),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .filtered_o(filtered_o));

    // Isolated variant on the same stimulus, watched for its whole-port enable
    pin_debounce_powerup #(.ISOLATED(1'b1), .N_LONG(N_SIM)) uut_iso (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(), .pu_image_i(pu_image_i),
        .fp_in_i(raw[15:0]), .dl_in_i(dl), .tb_in_i(raw[23:16]), .star_in_i(raw[24]),
        .pin_out_o(), .pin_oe_o(iso_oe), .filtered_o());

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Shift register for repeatable random values
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected power-up drive: enables, or levels when want_oe is low
    function automatic logic [31:0] pu_drive(input pu_image_t im, input logic want_oe);
        logic [23:0] v;
        v = '0;
        for (int i = 0; i < 24; i++) begin
            // Code 3 is treated as high impedance
            v[i] = want_oe ? (im.mode[i] == PU_LOW || im.mode[i] == PU_HIGH) : (im.mode[i] == PU_HIGH);
        end
        return {v[15:0], v[23:16], 8'h00};
    endfunction

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    // Reset with a given power-up image, then check pins in and after reset
    task automatic do_reset(input pu_image_t im);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        pu_image_i <= im;
        repeat (16) @(posedge clock_i);
        #1;
        check("oe in reset", pin_oe_o, 32'h00000000);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        // Image loads at the first edge, pins show it at the second
        repeat (2) @(posedge clock_i);
        #1;
        check("pu oe", pin_oe_o, pu_drive(im, 1'b1));
        check("pu out", pin_out_o, pu_drive(im, 1'b0));
        // Output-only lines fp6..fp9 switch together with the port enable
        check("iso pu oe", iso_oe, {6'h00, {4{im.port_en}}, 22'h000000});
        reg_rd(REG_FILT_PIN, rd_val);
        check("filt pin reset", rd_val, 32'h00000000);
    endtask

    // Pulse or bounce on one input, watching whether the filtered level rose
    task automatic pulse_chk(input int idx, input int width, input int gap, input int tail, input logic exp);
        int win;
        win = (gap > 0 ? 2 * width + gap : width) + tail;
        seen = 1'b0;
        fork
            if (gap > 0) src.bounce(idx, width, gap);
            else src.pulse(idx, width);
            repeat (win) begin
                @(posedge clock_i);
                #1;
                seen = seen | filtered_o[idx];
            end
        join
        check("pulse passed", seen, exp);
        check("level after", filtered_o[idx], 1'b0);
    endtask

    // Direct route: destination follows the raw source one clock later
    task automatic route_chk(input int idx, input logic [31:0] rv, input logic to_fp);
        reg_wr(REG_ROUTE, rv);
        fork
            src.pulse(idx, 3);
            begin
                repeat (2) @(posedge clock_i);
                #1;
                check("route oe", to_fp ? pin_oe_o.fp[0] : pin_oe_o.tb[0], 1'b1);
                check("route out", to_fp ? pin_out_o.fp[0] : pin_out_o.tb[0], 1'b1);
                check("route filt", filtered_o[idx], 1'b0);
            end
        join
        repeat (4) @(posedge clock_i);
    endtask

    // ****************************************************************
    // Closing and watchdog
    // ****************************************************************
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole sequence needs about 42 us; a hang past 200 us is a failure
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        img = '0;
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            img.mode[i] = lfsr[1:0];
            // Link lines stay undriven at power-up
            if (i inside {16, 17, 18, 20}) img.mode[i] = PU_HIZ;
        end
        lfsr = lfsr_next(lfsr);
        img.port_en = lfsr[2];
        do_reset(img);
        reg_rd(8'h40, rd_val);
        check("unmapped", rd_val, 32'h00000000);
        lfsr = lfsr_next(lfsr);
        dl <= lfsr[7:0];
        reg_rd(REG_LINE_IN, rd_val);
        check("line in", rd_val, {24'h000000, lfsr[7:0]});
        // Filters off: a one-clock pulse passes
        pulse_chk(2, 1, 0, 4, 1'b1);
        reg_wr(REG_FILT_PIN, 32'h00000001);
        pulse_chk(0, 10, 0, 25, 1'b0);
        pulse_chk(0, 13, 0, 25, 1'b1);
        pulse_chk(0, 10, 3, 25, 1'b0);
        pulse_chk(1, 1, 0, 4, 1'b1);
        reg_wr(REG_FILT_PIN, 32'h00000002);
        pulse_chk(0, 640, 0, 800, 1'b0);
        pulse_chk(0, 645, 0, 800, 1'b1);
        reg_wr(REG_FILT_PIN, 32'h00000003);
        pulse_chk(0, 45, 0, 70, 1'b0);
        pulse_chk(0, 55, 0, 70, 1'b1);
        // Every input on the short setting, random lines and widths
        reg_wr(REG_FILT_PIN, 32'h55555555);
        reg_wr(REG_FILT_BUS, 32'h00015555);
        pulse_chk(24, 10, 0, 25, 1'b0);
        pulse_chk(16, 13, 0, 25, 1'b1);
        reg_rd(REG_FILT_BUS, rd_val);
        check("filt bus", rd_val, 32'h00015555);
        for (int k = 0; k < 20; k++) begin
            lfsr = lfsr_next(lfsr);
            w = lfsr[4] ? 5 + int'(lfsr[7:5]) % 6 : 13 + int'(lfsr[10:8]);
            pulse_chk(int'(lfsr[31:16]) % 25, w, 0, 25, w >= 13);
        end
        // Raw routes bypass a mid filter in both directions
        reg_wr(REG_FILT_PIN, 32'h00000002);
        reg_wr(REG_FILT_BUS, 32'h00000002);
        route_chk(0, 32'h00000001, 1'b0);
        route_chk(16, 32'h00000100, 1'b1);
        reg_wr(REG_ROUTE, 32'h00000000);
        // Drive a non-link digital line high at run time
        reg_wr(REG_DRV_VAL, 32'h00080000);
        reg_wr(REG_DRV_EN, 32'h00080000);
        repeat (2) @(posedge clock_i);
        #1;
        check("drv oe", pin_oe_o.dl[3], 1'b1);
        check("drv out", pin_out_o.dl[3], 1'b1);
        reg_rd(REG_DRV_EN, rd_val);
        check("drv en", rd_val, 32'h00080000);
        // Second reset in mid-run with the default image: all lines undriven
        do_reset('0);
        print_verdict();
    end
endmodule
